// [gsm_seq_pkg.sv]
// Constants, register map and types for the burst data sequencer.
// Assumes a 25 MHz system clock and an AXI4-Lite master.
// Summary of operation
// RULE_01 - Source picks slot, frame, multiframe or superframe
// RULE_02 - One hundred burst stores, indices 0 to 99
// RULE_03 - Frame holds eight burst store indices
// RULE_04 - Multiframe holds 26 frame references
// RULE_05 - Superframe holds 51 multiframes; forty kept
// RULE_06 - Single shot plays once; continuous repeats
// RULE_07 - Burst bit order: tail, data, control, midamble
// RULE_08 - Guard bits always one, never editable
// RULE_09 - Store 0 is fixed null burst
// RULE_10 - Store 99 is fixed pseudo random sequence
// RULE_11 - Stored edits accepted for stores 1-98
// RULE_12 - Training code fills midamble with sequence
// RULE_13 - Setting cursor bit stores then advances
// RULE_14 - Field commands jump to adjacent field start
// RULE_15 - Generate starts streaming; halt stops it
// RULE_16 - Modulation off bypasses the generator
// RULE_17 - External clock honoured only outside master
// RULE_18 - Master drives bit clock out
// RULE_19 - Missing external clock raises no error
// RULE_20 - Burst stores retained across power cycles
// RULE_21 - External clock 270.833 kHz or 155+1.25 pattern
// RULE_22 - Discontinuous envelope suppresses edges, null bursts
// RULE_23 - Positions play ascending, one bit per period
package gsm_seq_pkg;
   localparam int SLOT_CNT   = 100;
   localparam int FRAME_CNT  = 100;
   localparam int MF_CNT     = 100;
   localparam int SF_CNT     = 40;
   localparam int FR_LEN     = 8;
   localparam int MF_LEN     = 26;
   localparam int SF_LEN     = 51;
   localparam int BURST_BITS = 148;
   localparam int SLOT_BITS  = 156;
   localparam int MID_START  = 61;
   localparam int MID_LEN    = 26;
   localparam int NULL_SLOT  = 0;
   localparam int PRBS_SLOT  = 99;
   localparam int EDIT_FIRST = 1;
   localparam int EDIT_LAST  = 98;
   localparam int CLK_HZ     = 25000000;
   localparam int BIT_HZ     = 270833;
   localparam int BIT_DIV    = CLK_HZ / BIT_HZ;
   localparam logic [7:0] FIELD_START [7] = '{8'h00, 8'h03, 8'h3C, 8'h3D, 8'h57, 8'h58, 8'h91};
   localparam logic [25:0] TRAIN_TBL [8] = '{26'h0970897, 26'h0B778B7, 26'h10EE90E, 26'h11ED11E,
                                           26'h06B906B, 26'h13AC13A, 26'h29F629F, 26'h3BC4BBC};
   localparam logic [8:0]  PRBS_SEED  = 9'h1FF;
   localparam logic [11:0] A_CTRL     = 12'h000;
   localparam logic [11:0] A_SRCNUM   = 12'h004;
   localparam logic [11:0] A_CMD      = 12'h008;
   localparam logic [11:0] A_CURSOR   = 12'h00C;
   localparam logic [11:0] A_ARG      = 12'h010;
   localparam logic [11:0] A_DESC     = 12'h014;
   localparam logic [11:0] A_STATUS   = 12'h018;
   localparam logic [11:0] A_EDITBIT  = 12'h01C;
   localparam int C_GEN = 0, C_HALT = 1, C_BIT0 = 2, C_BIT1 = 3, C_NEXTF = 4;
   localparam int C_PREVF = 5, C_TRN = 6, C_STORE = 7, C_LOAD = 8, C_CLRREJ = 9;
   localparam logic [1:0] SRC_SLOT = 2'h0, SRC_FRAME = 2'h1, SRC_MF = 2'h2, SRC_SF = 2'h3;
   localparam logic [1:0] CFG_SA = 2'h0, CFG_MASTER = 2'h1, CFG_SLAVE = 2'h2;
   localparam logic [1:0] RESP_OK = 2'h0, RESP_DEC = 2'h3;
   localparam logic [7:0] CTRL_RST = 8'h00;
   typedef struct packed {
      logic       discont;
      logic [1:0] cfg;
      logic       ext_clk;
      logic [1:0] source;
      logic       continuous;
      logic       mod_on;
   } ctrl_t;
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} run_t;
endpackage : gsm_seq_pkg

// [gsm_burst_data_sequencer.sv]
// Burst data sequencer: stores, descriptors, editor and bit streamer.
// Assumes an AXI4-Lite master and an optional asynchronous bit clock pin.
`timescale 1ns/1ps
module gsm_burst_data_sequencer (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [11:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Bit clock
   input  wire logic        ext_bit_clk_i,
   output logic             bit_clk_o,
   output logic             bit_clk_oe_o,
   // Modulator side
   output logic             data_o,
   output logic             bit_strobe_o,
   output logic             rf_suppress_o,
   output logic             bypass_o
);
   import gsm_seq_pkg::*;

   // Stores, no reset so contents survive
   logic [BURST_BITS-1:0] burst_mem [SLOT_CNT];
   logic [6:0]            fr_mem [FRAME_CNT*FR_LEN];
   logic [6:0]            mf_mem [MF_CNT*MF_LEN];
   logic [6:0]            sf_mem [SF_CNT*SF_LEN];

   ctrl_t                 ctrl;
   logic [6:0]            src_num;
   logic [7:0]            cursor;
   logic [6:0]            arg;
   logic [BURST_BITS-1:0] edit_buf;
   logic                  store_rej;
   run_t                  state;
   logic [7:0]            bit_pos;
   logic [2:0]            fr_pos;
   logic [4:0]            mf_pos;
   logic [5:0]            sf_pos;
   logic [8:0]            prbs;
   logic [6:0]            div_cnt;
   logic                  int_tick;
   logic [2:0]            ext_sync;
   logic                  aw_have;
   logic                  w_have;
   logic [11:0]           aw_addr;
   logic [31:0]           w_data;

   function automatic logic [7:0] next_field(input logic [7:0] c);
      logic [7:0] r;
      r = c;
      for (int i = 6; i >= 0; i--) begin
         if (FIELD_START[i] > c) begin
            r = FIELD_START[i];
         end
      end
      return r;
   endfunction : next_field

   function automatic logic [7:0] prev_field(input logic [7:0] c);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 7; i++) begin
         if (FIELD_START[i] < c) begin
            r = FIELD_START[i];
         end
      end
      return r;
   endfunction : prev_field

   // Write decode
   wire logic        do_write = aw_have && w_have && !s_axi_bvalid_o;
   wire logic        wr_ctrl  = do_write && (aw_addr == A_CTRL);
   wire logic        wr_num   = do_write && (aw_addr == A_SRCNUM);
   wire logic        wr_cmd   = do_write && (aw_addr == A_CMD);
   wire logic        wr_cur   = do_write && (aw_addr == A_CURSOR);
   wire logic        wr_arg   = do_write && (aw_addr == A_ARG);
   wire logic        wr_desc  = do_write && (aw_addr == A_DESC);
   wire logic        wr_hit   = wr_ctrl || wr_num || wr_cmd || wr_cur || wr_arg || wr_desc
                                || (aw_addr == A_STATUS) || (aw_addr == A_EDITBIT);
   wire logic        cmd_gen  = wr_cmd && w_data[C_GEN];
   wire logic        cmd_halt = wr_cmd && w_data[C_HALT];
   wire logic        cmd_b0   = wr_cmd && w_data[C_BIT0];
   wire logic        cmd_b1   = wr_cmd && w_data[C_BIT1];
   wire logic        cmd_nf   = wr_cmd && w_data[C_NEXTF];
   wire logic        cmd_pf   = wr_cmd && w_data[C_PREVF];
   wire logic        cmd_trn  = wr_cmd && w_data[C_TRN];
   wire logic        cmd_st   = wr_cmd && w_data[C_STORE];
   wire logic        cmd_ld   = wr_cmd && w_data[C_LOAD];
   wire logic        cmd_clr  = wr_cmd && w_data[C_CLRREJ];
   wire logic        st_ok    = (arg >= 7'(EDIT_FIRST)) && (arg <= 7'(EDIT_LAST)); // RULE_09 RULE_10 RULE_11
   wire logic        do_store = cmd_st && st_ok;
   wire logic        st_bad   = cmd_st && !st_ok;
   wire logic [1:0]  d_kind   = w_data[25:24];
   wire logic [6:0]  d_entry  = w_data[22:16];
   wire logic [5:0]  d_pos    = w_data[13:8];
   wire logic [6:0]  d_val    = w_data[6:0];
   wire logic        d_valok  = d_val < 7'(SLOT_CNT);
   wire logic        d_fr     = wr_desc && d_kind == 2'h0 && d_entry < 7'(FRAME_CNT)
                                && d_pos < 6'(FR_LEN) && d_valok; // RULE_03
   wire logic        d_mf     = wr_desc && d_kind == 2'h1 && d_entry < 7'(MF_CNT)
                                && d_pos < 6'(MF_LEN) && d_valok; // RULE_04
   wire logic        d_sf     = wr_desc && d_kind == 2'h2 && d_entry < 7'(SF_CNT)
                                && d_pos < 6'(SF_LEN) && d_valok; // RULE_05
   wire logic [9:0]  d_fra    = 10'(d_entry) * 10'(FR_LEN) + 10'(d_pos);
   wire logic [11:0] d_mfa    = 12'(d_entry) * 12'(MF_LEN) + 12'(d_pos);
   wire logic [10:0] d_sfa    = 11'(d_entry) * 11'(SF_LEN) + 11'(d_pos);
   wire logic [25:0] trn_seq  = TRAIN_TBL[arg[2:0]];

   // Structure walk: superframe to multiframe to frame to slot
   wire logic        running  = state == ST_RUN;
   wire logic [1:0]  src      = ctrl.source; // RULE_01
   wire logic [10:0] sf_addr  = 11'(src_num) * 11'(SF_LEN) + 11'(sf_pos);
   wire logic [6:0]  mf_idx   = (src == SRC_SF) ? sf_mem[sf_addr] : src_num;
   wire logic [11:0] mf_addr  = 12'(mf_idx) * 12'(MF_LEN) + 12'(mf_pos);
   wire logic [6:0]  fr_idx   = (src >= SRC_MF) ? mf_mem[mf_addr] : src_num;
   wire logic [9:0]  fr_addr  = 10'(fr_idx) * 10'(FR_LEN) + 10'(fr_pos);
   wire logic [6:0]  slot_idx = (src == SRC_SLOT) ? src_num : fr_mem[fr_addr];
   wire logic        in_burst = bit_pos < 8'(BURST_BITS); // RULE_07
   wire logic        is_null  = slot_idx == 7'(NULL_SLOT);
   wire logic        is_prbs  = slot_idx == 7'(PRBS_SLOT);
   wire logic        mem_bit  = burst_mem[slot_idx][bit_pos]; // RULE_02
   wire logic        next_bit = !in_burst ? 1'b1 // RULE_08
                                : is_null ? 1'b0 // RULE_09
                                : is_prbs ? prbs[0] // RULE_10
                                : mem_bit;
   wire logic        last_bit = bit_pos == 8'(SLOT_BITS - 1);
   wire logic        last_fr  = (src == SRC_SLOT) || (fr_pos == 3'(FR_LEN - 1));
   wire logic        last_mf  = (src < SRC_MF) || (mf_pos == 5'(MF_LEN - 1));
   wire logic        last_sf  = (src < SRC_SF) || (sf_pos == 6'(SF_LEN - 1));
   wire logic        s_end    = last_bit && last_fr && last_mf && last_sf;
   wire logic        num_ok   = (src == SRC_SF) ? (src_num < 7'(SF_CNT)) : (src_num < 7'(SLOT_CNT));

   // Bit clock selection
   wire logic        use_ext  = ctrl.ext_clk && (ctrl.cfg != CFG_MASTER); // RULE_17
   wire logic        ext_rise = ext_sync[1] && !ext_sync[2]; // RULE_21
   wire logic        tick     = use_ext ? ext_rise : int_tick; // RULE_19
   wire logic        adv      = tick && running;

   // Read mux
   wire logic [31:0] status_w = {16'h0000, 1'b0, slot_idx, 6'h00, store_rej, running};
   wire logic        rd_hit   = (s_axi_araddr_i <= A_EDITBIT) && (s_axi_araddr_i[1:0] == 2'h0);
   wire logic [31:0] rd_data  = (s_axi_araddr_i == A_CTRL)    ? {24'h000000, ctrl}
                              : (s_axi_araddr_i == A_SRCNUM)  ? {25'h0000000, src_num}
                              : (s_axi_araddr_i == A_CURSOR)  ? {24'h000000, cursor}
                              : (s_axi_araddr_i == A_ARG)     ? {25'h0000000, arg}
                              : (s_axi_araddr_i == A_STATUS)  ? status_w
                              : (s_axi_araddr_i == A_EDITBIT) ? {31'h00000000, edit_buf[cursor]}
                              : 32'h00000000;

   // AXI write channel
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_have         <= 1'b0;
         w_have          <= 1'b0;
         aw_addr         <= 12'h000;
         w_data          <= 32'h00000000;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= RESP_OK;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have         <= 1'b1;
            aw_addr         <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            s_axi_wready_o <= 1'b0;
         end
         if (do_write) begin
            aw_have        <= 1'b0;
            w_have         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? RESP_OK : RESP_DEC;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // AXI read channel
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= rd_hit ? rd_data : 32'h00000000;
         s_axi_rresp_o   <= rd_hit ? RESP_OK : RESP_DEC;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl    <= ctrl_t'(CTRL_RST);
         src_num <= 7'h00;
         arg     <= 7'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl <= ctrl_t'(w_data[7:0]);
         end
         if (wr_num && w_data[6:0] < 7'(SLOT_CNT)) begin
            src_num <= w_data[6:0];
         end
         if (wr_arg) begin
            arg <= w_data[6:0];
         end
      end
   end

   // Editor buffer and cursor
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edit_buf  <= '0;
         cursor    <= 8'h00;
         store_rej <= 1'b0;
      end else begin
         if (cmd_b0 || cmd_b1) begin
            edit_buf[cursor] <= cmd_b1; // RULE_13
            cursor <= (cursor == 8'(BURST_BITS - 1)) ? cursor : cursor + 8'h01; // RULE_13
         end else if (cmd_nf) begin
            cursor <= next_field(cursor); // RULE_14
         end else if (cmd_pf) begin
            cursor <= prev_field(cursor); // RULE_14
         end else if (wr_cur && w_data[7:0] < 8'(BURST_BITS)) begin
            cursor <= w_data[7:0];
         end
         if (cmd_trn) begin
            for (int i = 0; i < MID_LEN; i++) begin
               edit_buf[MID_START + i] <= trn_seq[MID_LEN - 1 - i]; // RULE_12
            end
         end else if (cmd_ld && arg < 7'(SLOT_CNT)) begin
            edit_buf <= (arg == 7'(NULL_SLOT)) ? '0 : burst_mem[arg];
         end
         if (st_bad) begin
            store_rej <= 1'b1; // RULE_11
         end else if (cmd_clr) begin
            store_rej <= 1'b0;
         end
      end
   end

   // Non-volatile stores
   always_ff @(posedge clk_i) begin
      if (do_store) begin
         burst_mem[arg] <= edit_buf; // RULE_20 RULE_11
      end
      if (d_fr) begin
         fr_mem[d_fra] <= d_val; // RULE_03
      end
      if (d_mf) begin
         mf_mem[d_mfa] <= d_val; // RULE_04
      end
      if (d_sf) begin
         sf_mem[d_sfa] <= d_val; // RULE_05
      end
   end

   // Bit clock divider and pin synchroniser
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt  <= 7'h00;
         int_tick <= 1'b0;
         ext_sync <= 3'h0;
      end else begin
         int_tick <= div_cnt == 7'(BIT_DIV - 1);
         div_cnt  <= (div_cnt == 7'(BIT_DIV - 1)) ? 7'h00 : div_cnt + 7'h01;
         ext_sync <= {ext_sync[1:0], ext_bit_clk_i};
      end
   end

   // Bit clock out in master configuration
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_clk_o    <= 1'b0;
         bit_clk_oe_o <= 1'b0;
      end else begin
         bit_clk_oe_o <= ctrl.cfg == CFG_MASTER; // RULE_18
         bit_clk_o    <= (ctrl.cfg == CFG_MASTER) && (div_cnt < 7'(BIT_DIV / 2)); // RULE_18
      end
   end

   // Sequencer
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state   <= ST_IDLE;
         bit_pos <= 8'h00;
         fr_pos  <= 3'h0;
         mf_pos  <= 5'h00;
         sf_pos  <= 6'h00;
         prbs    <= PRBS_SEED;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_gen && num_ok) begin
                  state   <= ST_RUN; // RULE_15
                  bit_pos <= 8'h00;
                  fr_pos  <= 3'h0;
                  mf_pos  <= 5'h00;
                  sf_pos  <= 6'h00;
                  prbs    <= PRBS_SEED;
               end
            end
            ST_RUN: begin
               if (cmd_halt) begin
                  state <= ST_IDLE; // RULE_15
               end else if (adv) begin
                  bit_pos <= last_bit ? 8'h00 : bit_pos + 8'h01; // RULE_23
                  if (in_burst && is_prbs) begin
                     prbs <= {prbs[0] ^ prbs[4], prbs[8:1]}; // RULE_10
                  end
                  if (last_bit) begin
                     fr_pos <= last_fr ? 3'h0 : fr_pos + 3'h1; // RULE_23
                  end
                  if (last_bit && last_fr) begin
                     mf_pos <= last_mf ? 5'h00 : mf_pos + 5'h01; // RULE_23
                  end
                  if (last_bit && last_fr && last_mf) begin
                     sf_pos <= last_sf ? 6'h00 : sf_pos + 6'h01; // RULE_23
                  end
                  if (s_end && !ctrl.continuous) begin
                     state <= ST_IDLE; // RULE_06
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Modulator outputs
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_o        <= 1'b1;
         bit_strobe_o  <= 1'b0;
         rf_suppress_o <= 1'b0;
         bypass_o      <= 1'b1;
      end else begin
         bit_strobe_o  <= adv && !cmd_halt;
         if (adv && !cmd_halt) begin
            data_o <= next_bit; // RULE_07
         end
         bypass_o      <= !ctrl.mod_on; // RULE_16
         rf_suppress_o <= ctrl.discont && (!running || !in_burst || is_null); // RULE_22
      end
   end
endmodule : gsm_burst_data_sequencer

// [gsm_seq_checker.sv]
// Checker: bus handshakes, bit strobe and clock out of the sequencer.
// Assumes binding to the sequencer top; one clock domain, reset active low.
`timescale 1ns/1ps
module gsm_seq_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Bus handshakes
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   // Stream and clock out
   input wire logic bit_clk_o,
   input wire logic bit_clk_oe_o,
   input wire logic data_o,
   input wire logic bit_strobe_o,
   input wire logic bypass_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   AST_WR_ANSWER: assert property (
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
      else $error("write answer late");
   AST_AW_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken during response");
   AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read taken during response");
   AST_OE_CLK: assert property (!bit_clk_oe_o |-> !bit_clk_o)
      else $error("bit clock out while not driven");
   AST_STROBE_GAP: assert property (bit_strobe_o |=> !bit_strobe_o [*6])
      else $error("bit strobes too close");
   AST_DATA_HOLD: assert property (!bit_strobe_o |-> $stable(data_o))
      else $error("data moved without strobe");
   AST_BYPASS: assert property ($changed(bypass_o) |-> $past(s_axi_bvalid_o))
      else $error("bypass moved without write");
endmodule : gsm_seq_checker

bind gsm_burst_data_sequencer gsm_seq_checker chk (.*);

// [gmsk_mod_model.sv]
// Modulator model: collects streamed bits and offers an external bit clock.
// Assumes the bench enables the clock while external timing is wanted, and also in master configuration and while halted, where it must be ignored.
`timescale 1ns/1ps
module gmsk_mod_model (
   // System side
   input  wire logic clk_i,
   input  wire logic ext_en_i,
   // Stream from the sequencer
   input  wire logic data_i,
   input  wire logic strobe_i,
   input  wire logic suppress_i,
   // Bit clock to the sequencer
   output logic      ext_bit_clk_o
);
   logic [1:0] q [$];
   initial begin
      ext_bit_clk_o = 1'b0;
      #7;
      forever begin
         #160;
         ext_bit_clk_o = ext_en_i ? ~ext_bit_clk_o : 1'b0;
      end
   end
   always @(posedge clk_i) begin
      if (strobe_i === 1'b1) q.push_back({suppress_i, data_i});
   end
endmodule : gmsk_mod_model

// [tb.sv]
// Testbench: registers, editing and streaming of the sequencer.
// Assumes the modulator model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb;
   import gsm_seq_pkg::*;
   logic        clk_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready, ext_en;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic        awready, wready, bvalid, arready, rvalid, ext_clk, bclk, bclk_oe, dat, strb, sup, byp;
   int          err_count, tests_run;
   gsm_burst_data_sequencer dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .ext_bit_clk_i(ext_clk), .bit_clk_o(bclk), .bit_clk_oe_o(bclk_oe),
      .data_o(dat), .bit_strobe_o(strb), .rf_suppress_o(sup), .bypass_o(byp));
   gmsk_mod_model m (.clk_i(clk_i), .ext_en_i(ext_en), .data_i(dat), .strobe_i(strb), .suppress_i(sup),
      .ext_bit_clk_o(ext_clk));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #3000000;
      err_count++;
      tally_and_finish();
   end
   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk_i);
   endtask : rdr
   task automatic cm(input int b, input logic [31:0] arg);
      wr(A_ARG, arg);
      wr(A_CMD, 32'h1 << b);
   endtask : cm
   task automatic wait_bits(input int n);
      while (m.q.size() < n) @(posedge clk_i);
   endtask : wait_bits
   function automatic logic eb(input bit nul, input int i);
      if (i >= BURST_BITS) return 1'b1;
      if (nul) return 1'b0;
      if (i >= MID_START && i < MID_START + MID_LEN) return TRAIN_TBL[0][MID_LEN - 1 - (i - MID_START)];
      return (i == 3 || i == 5);
   endfunction : eb
   task automatic chk_stream(input int n, input bit fr, input bit sp);
      logic [1:0] v;
      bit         nul;
      for (int i = 0; i < n; i++) begin
         v = m.q.pop_front();
         nul = fr && ((i / SLOT_BITS) % 2 == 1);
         chk({31'h0, v[0]}, {31'h0, eb(nul, i % SLOT_BITS)});
         if (sp) chk({31'h0, v[1]}, {31'h0, (i % SLOT_BITS >= BURST_BITS) || nul});
      end
   endtask : chk_stream
   task automatic t_regs();
      chk({28'h0, byp, dat, strb, bclk_oe}, 32'hC);
      rdr(A_CTRL);
      chk(rd, 32'h0);
      rdr(12'h020);
      chk({rd[29:0], rs}, {30'h0, RESP_DEC});
      wr(12'h040, 32'h1);
      chk({30'h0, rs}, {30'h0, RESP_DEC});
      wr(A_SRCNUM, 32'h5);
      wr(A_SRCNUM, 32'h64);
      rdr(A_SRCNUM);
      chk(rd, 32'h5);
   endtask : t_regs
   task automatic t_edit();
      cm(C_LOAD, 32'h0);
      cm(C_TRN, 32'h0);
      wr(A_CURSOR, 32'h3);
      cm(C_BIT1, 32'h0);
      cm(C_BIT0, 32'h0);
      cm(C_BIT1, 32'h0);
      rdr(A_CURSOR);
      chk(rd, 32'h6);
      wr(A_CURSOR, 32'h5);
      rdr(A_EDITBIT);
      chk(rd, 32'h1);
      cm(C_NEXTF, 32'h0);
      rdr(A_CURSOR);
      chk(rd, 32'h3C);
      cm(C_PREVF, 32'h0);
      rdr(A_CURSOR);
      chk(rd, 32'h3);
      cm(C_STORE, 32'h5);
      for (int s = 0; s < 2; s++) begin
         cm(C_STORE, s ? 32'h63 : 32'h0);
         rdr(A_STATUS);
         chk({31'h0, rd[1]}, 32'h1);
         cm(C_CLRREJ, 32'h0);
      end
   endtask : t_edit
   task automatic t_single();
      wr(A_CTRL, 32'h01);
      chk({31'h0, byp}, 32'h0);
      m.q.delete();
      cm(C_GEN, 32'h0);
      wait_bits(SLOT_BITS);
      repeat (200) @(posedge clk_i);
      rdr(A_STATUS);
      chk({31'h0, rd[0]}, 32'h0);
      chk(m.q.size(), SLOT_BITS);
      chk_stream(SLOT_BITS, 1'b0, 1'b0);
   endtask : t_single
   task automatic t_frame();
      for (int p = 0; p < FR_LEN; p++) wr(A_DESC, 32'h0003_0000 | (p << 8) | (p % 2 ? 0 : 5));
      ext_en <= 1'b1;
      wr(A_CTRL, 32'hD5);
      wr(A_SRCNUM, 32'h3);
      m.q.delete();
      cm(C_GEN, 32'h0);
      wait_bits(FR_LEN * SLOT_BITS);
      chk_stream(FR_LEN * SLOT_BITS, 1'b1, 1'b1);
      repeat (40) @(posedge clk_i);
      chk({31'h0, sup}, 32'h1);
   endtask : t_frame
   task automatic t_cont();
      wr(A_CTRL, 32'h53);
      wr(A_SRCNUM, 32'h5);
      m.q.delete();
      cm(C_GEN, 32'h0);
      wait_bits(SLOT_BITS + 20);
      ext_en <= 1'b0;
      chk_stream(SLOT_BITS + 20, 1'b0, 1'b0);
      repeat (100) @(posedge clk_i);
      rdr(A_STATUS);
      chk({30'h0, rd[1:0]}, 32'h1);
      cm(C_HALT, 32'h0);
      rdr(A_STATUS);
      chk({31'h0, rd[0]}, 32'h0);
      ext_en <= 1'b1;
      m.q.delete();
      repeat (100) @(posedge clk_i);
      chk(m.q.size(), 0);
      ext_en <= 1'b0;
      wr(A_CTRL, 32'h52);
      chk({31'h0, byp}, 32'h1);
   endtask : t_cont
   task automatic t_sources();
      wr(A_CTRL, 32'h5D);
      wr(A_SRCNUM, 32'h2D);
      cm(C_GEN, 32'h0);
      rdr(A_STATUS);
      chk({31'h0, rd[0]}, 32'h0);
      wr(A_CTRL, 32'h59);
      cm(C_GEN, 32'h0);
      rdr(A_STATUS);
      chk({31'h0, rd[0]}, 32'h1);
      cm(C_HALT, 32'h0);
   endtask : t_sources
   task automatic t_master();
      int c;
      int h;
      ext_en <= 1'b1;
      wr(A_CTRL, 32'h31);
      cm(C_GEN, 32'h0);
      chk({31'h0, bclk_oe}, 32'h1);
      for (c = 0; c < 200 && strb !== 1'b1; c++) @(posedge clk_i);
      c = 0;
      h = 0;
      do begin
         @(posedge clk_i);
         c++;
         h += bclk;
      end while (strb !== 1'b1 && c < 200);
      chk(c, BIT_DIV);
      chk(h, BIT_DIV / 2);
      cm(C_HALT, 32'h0);
   endtask : t_master
   initial begin
      rst_b_i = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, ext_en} = 6'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_edit();
      t_single();
      t_frame();
      t_cont();
      t_sources();
      t_master();
      tally_and_finish();
   end
endmodule : tb
